// File: rtl/dpw_bit_if.sv
// interface: bit-level events from the serial front end
`timescale 1ns/1ps
interface dpw_bit_if;
   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;
   logic sda_val;
   modport fe  (output start_ev, output stop_ev, output rise_ev, output fall_ev, output sda_val);
   modport cmd (input start_ev, input stop_ev, input rise_ev, input fall_ev, input sda_val);
endinterface : dpw_bit_if

// File: rtl/dpw_pkg.sv
// package: constants for the wiper command handler
package dpw_pkg;
   localparam logic [6:0] POT_ADDR      = 7'h57;   // 1010111
   localparam logic [1:0] SEL_POT64     = 2'h0;
   localparam logic [1:0] SEL_POT100    = 2'h1;
   localparam logic [1:0] SEL_POT256    = 2'h2;
   localparam logic [1:0] SEL_RESERVED  = 2'h3;
   localparam logic [7:0] MAX_POT64     = 8'h3F;
   localparam logic [7:0] MAX_POT100    = 8'h7F;
   localparam logic [7:0] MAX_POT256    = 8'hFF;
   localparam logic [7:0] NV_DEFAULT    = 8'h00;
   localparam int         WT_BIT        = 7;
   localparam int         CLK_MHZ       = 125;
   localparam int         PROG_TIME_US  = 5000;
   localparam int         PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : dpw_pkg

// File: rtl/dpw_sync.sv
// serial line synchroniser and edge / condition detector
`timescale 1ns/1ps
module dpw_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   dpw_bit_if.fe     ev
);
   logic [1:0] scl_s_q;
   logic [1:0] sda_s_q;
   logic       scl_q;
   logic       sda_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         scl_q   <= scl_s_q[1];
         sda_q   <= sda_s_q[1];
      end
   end

   assign ev.rise_ev  = scl_s_q[1] & ~scl_q;
   assign ev.fall_ev  = ~scl_s_q[1] & scl_q;
   assign ev.start_ev = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
   assign ev.stop_ev  = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
   assign ev.sda_val  = sda_s_q[1];
endmodule : dpw_sync

// File: rtl/dpw_top.sv
// wiper command handler: serial command decode, wiper and stored copies
// ------------------------------------------------------------
// Function
// - nonvolatile write updates wiper register and stored copy together
// - volatile write updates wiper register only
// - writes are address byte, instruction byte, data byte
// - instruction decoded only when address top seven bits are 1010111
// - select field 00, 01, 10 picks 64, 100, 256 tap unit
// - instruction top bit 1 means nonvolatile, 0 volatile
// - write kind bit ignored in read address phase
// - write opens with 10101110, device acknowledges it
// - valid instruction byte gets a second acknowledge
// - data loads on rising clock of lowest bit, before the ack clock
// - maxima 3Fh and FFh, 100-tap unit own mapping
// - codes above maximum clamp to highest tap, no wrap
// - 64 and 256 tap codes equal tap number
// - select field 11 reserved, no acknowledge
// - each write independent of previous value
// - stored copies shipped as zero
// - read is dummy write, repeated start, read address, one byte
// - read returns volatile wiper register of selected unit
// - unused upper read bits undefined per unit
// - nonvolatile write starts programming cycle blocking commands
// - no address acknowledge while programming
// - wiper registers load from stored copies at power-up
// ------------------------------------------------------------
`timescale 1ns/1ps
module dpw_top #(
   parameter int PROG_CYCLES = dpw_pkg::PROG_CYCLES
) (
   input  wire logic       CLK_SYS,
   input  wire logic       SYS_RST,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_N,
   input  wire logic       WRITE_PERMIT_LATCH,
   output logic [7:0]      WIPER_POT64,
   output logic [7:0]      WIPER_POT100,
   output logic [7:0]      WIPER_POT256,
   output logic [7:0]      STORED_POT64,
   output logic [7:0]      STORED_POT100,
   output logic [7:0]      STORED_POT256,
   output logic            PROG_BUSY
);
   // ------------------------------------------------------------
   // front end
   // ------------------------------------------------------------
   dpw_bit_if ev ();

   dpw_sync u_sync (
      .clk    (CLK_SYS),
      .rst    (SYS_RST),
      .scl_in (SCL_IN),
      .sda_in (SDA_IN),
      .ev     (ev)
   );

   logic [1:0] wel_s_q;
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         wel_s_q <= 2'h0;
      end else begin
         wel_s_q <= {wel_s_q[0], WRITE_PERMIT_LATCH};
      end
   end

   // ------------------------------------------------------------
   // protocol state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_INSTR = 3'b010,
      ST_DATA  = 3'b011,
      ST_READ  = 3'b100,
      ST_MACK  = 3'b101,
      ST_SKIP  = 3'b110
   } dpw_state_e;

   dpw_state_e st_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic       ack_q;
   logic [1:0] sel_q;
   logic       wt_q;
   logic       is_read_q;
   logic       instr_ok_q;
   logic       nv_pend_q;
   logic [7:0] rd_q;
   logic [31:0] prog_q;
   logic [7:0] wiper_q [3];
   logic [7:0] stored_q [3];
   logic       recall_q;

   logic [7:0] byte_in;
   logic       byte_done;
   logic       busy;
   assign byte_in   = {shift_q[6:0], ev.sda_val};
   assign byte_done = ev.rise_ev && (bit_q == dpw_pkg::BITS_PER_BYTE - 4'h1) && !ack_q;
   assign busy      = (prog_q != 32'h0000_0000);

   function automatic logic [7:0] clamp(input logic [1:0] sel, input logic [7:0] v);
      logic [7:0] mx;
      mx = (sel == dpw_pkg::SEL_POT64)  ? dpw_pkg::MAX_POT64 :
           (sel == dpw_pkg::SEL_POT100) ? dpw_pkg::MAX_POT100 : dpw_pkg::MAX_POT256;
      return (v > mx) ? mx : v;
   endfunction : clamp

   // ------------------------------------------------------------
   // byte sequencer
   // ------------------------------------------------------------
   logic do_write;
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         st_q       <= ST_IDLE;
         bit_q      <= 4'h0;
         shift_q    <= 8'h00;
         ack_q      <= 1'b0;
         sel_q      <= 2'h0;
         wt_q       <= 1'b0;
         is_read_q  <= 1'b0;
         instr_ok_q <= 1'b0;
         nv_pend_q  <= 1'b0;
         do_write   <= 1'b0;
      end else begin
         do_write <= 1'b0;
         if (ev.stop_ev) begin
            st_q <= ST_IDLE;
            ack_q <= 1'b0;
         end else if (ev.start_ev) begin
            st_q  <= ST_ADDR;  // repeated start also lands here
            bit_q <= 4'h0;
            ack_q <= 1'b0;
         end else if (ev.rise_ev && !ack_q && st_q != ST_IDLE && st_q != ST_READ &&
                      st_q != ST_MACK) begin
            shift_q <= byte_in;
            bit_q   <= bit_q + 4'h1;
            if (byte_done) begin
               bit_q <= 4'h0;
               case (st_q)
                  ST_ADDR: begin
                     if (byte_in[7:1] == dpw_pkg::POT_ADDR && !busy) begin
                        ack_q     <= 1'b1;
                        is_read_q <= byte_in[0];
                        st_q      <= (byte_in[0] && instr_ok_q) ? ST_READ : ST_INSTR;
                     end else begin
                        st_q <= ST_SKIP;
                     end
                  end
                  ST_INSTR: begin
                     sel_q <= byte_in[1:0];
                     wt_q  <= byte_in[dpw_pkg::WT_BIT];
                     if (byte_in[1:0] != dpw_pkg::SEL_RESERVED) begin
                        ack_q      <= 1'b1;
                        instr_ok_q <= 1'b1;
                        st_q       <= ST_DATA;
                     end else begin
                        instr_ok_q <= 1'b0;
                        st_q       <= ST_SKIP;
                     end
                  end
                  ST_DATA: begin
                     ack_q    <= 1'b1;
                     do_write <= wel_s_q[1];
                     nv_pend_q <= wel_s_q[1] & wt_q;
                     st_q     <= ST_SKIP;
                  end
                  default: st_q <= ST_SKIP;
               endcase
            end
         end else if (ev.fall_ev && ack_q && ack_drive_q) begin
            ack_q <= 1'b0;  // ack slot ends on the falling edge after its own rise
         end else if (ev.rise_ev && st_q == ST_READ && !ack_q) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == dpw_pkg::BITS_PER_BYTE - 4'h1) begin
               st_q  <= ST_MACK;
               bit_q <= 4'h0;
            end
         end else if (ev.rise_ev && st_q == ST_MACK) begin
            st_q <= ST_SKIP;  // one byte only
         end
         if (ev.stop_ev) begin
            nv_pend_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // ack / read drive; ack applied after the falling edge of the 8th bit
   // ------------------------------------------------------------
   logic ack_drive_q;
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ack_drive_q <= 1'b0;
      end else if (ev.start_ev || ev.stop_ev) begin
         ack_drive_q <= 1'b0;
      end else if (ev.fall_ev) begin
         ack_drive_q <= ack_q && !ack_drive_q;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         rd_q <= 8'h00;
      end else if (ev.fall_ev && ack_q && st_q == ST_READ) begin
         rd_q <= wiper_q[sel_q];
      end else if (ev.fall_ev && st_q == ST_READ && !ack_drive_q) begin
         rd_q <= {rd_q[6:0], 1'b1};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         SDA_OUT  <= 1'b1;
         SDA_OE_N <= 1'b1;
      end else if (ev.start_ev || ev.stop_ev) begin
         SDA_OUT  <= 1'b1;
         SDA_OE_N <= 1'b1;
      end else if (ev.fall_ev) begin
         if (ack_q && !ack_drive_q) begin
            SDA_OUT  <= 1'b0;
            SDA_OE_N <= 1'b0;
         end else if (st_q == ST_READ) begin
            // after the first data bit rd_q shifts on this same edge: show the bit that moves into the top
            SDA_OUT  <= ack_q ? rd_q[7] : rd_q[6];
            SDA_OE_N <= 1'b0;
         end else begin
            SDA_OUT  <= 1'b1;
            SDA_OE_N <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // programming cycle
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         prog_q <= 32'h0000_0000;
      end else if (ev.stop_ev && nv_pend_q) begin
         prog_q <= 32'(PROG_CYCLES);
      end else if (busy) begin
         prog_q <= prog_q - 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------
   // wiper and stored copies
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         recall_q <= 1'b1;
      end else begin
         recall_q <= 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pot
         always_ff @(posedge CLK_SYS) begin
            if (SYS_RST) begin
               stored_q[gi] <= dpw_pkg::NV_DEFAULT;
            end else if (do_write && wt_q && sel_q == 2'(gi)) begin
               stored_q[gi] <= clamp(sel_q, shift_q);
            end
         end
         always_ff @(posedge CLK_SYS) begin
            if (SYS_RST) begin
               wiper_q[gi] <= dpw_pkg::NV_DEFAULT;
            end else if (recall_q) begin
               wiper_q[gi] <= stored_q[gi];
            end else if (do_write && sel_q == 2'(gi)) begin
               wiper_q[gi] <= clamp(sel_q, shift_q);
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         WIPER_POT64   <= dpw_pkg::NV_DEFAULT;
         WIPER_POT100  <= dpw_pkg::NV_DEFAULT;
         WIPER_POT256  <= dpw_pkg::NV_DEFAULT;
         STORED_POT64  <= dpw_pkg::NV_DEFAULT;
         STORED_POT100 <= dpw_pkg::NV_DEFAULT;
         STORED_POT256 <= dpw_pkg::NV_DEFAULT;
         PROG_BUSY     <= 1'b0;
      end else begin
         WIPER_POT64   <= wiper_q[0];
         WIPER_POT100  <= wiper_q[1];
         WIPER_POT256  <= wiper_q[2];
         STORED_POT64  <= stored_q[0];
         STORED_POT100 <= stored_q[1];
         STORED_POT256 <= stored_q[2];
         PROG_BUSY     <= busy;
      end
   end
endmodule : dpw_top

// File: test/dpw_mst.sv
// two-wire bus master model driving the serial pins
`timescale 1ns/1ps
module dpw_mst (
   input  wire logic clk,
   input  wire logic dev_sda,
   input  wire logic dev_oe_n,
   output logic      scl,
   output wire logic sda
);
   logic drv_q = 1'b1;
   initial scl = 1'b1;
   // pulled-up line: low only while one side pulls it low
   assign sda = drv_q && !(dev_oe_n === 1'b0 && dev_sda === 1'b0);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // start is (1,0), stop is (0,1); the clock stays high after a stop
   task automatic cond(input logic d0, input logic d1);
      tick(1);
      drv_q <= d0;
      tick(3);
      scl <= 1'b1;
      tick(4);
      drv_q <= d1;
      tick(4);
      scl <= d1;
   endtask : cond
   // eight bits msb first, then the ack slot driven with mack
   task automatic byte_x(input logic [7:0] tx, input logic mack,
                         output logic [7:0] rx, output logic ack);
      logic [8:0] v;
      logic [8:0] s;
      v = {tx, mack};
      for (int i = 8; i >= 0; i--) begin
         tick(1);
         drv_q <= v[i];
         tick(3);
         scl <= 1'b1;
         tick(4);
         s[i] = sda;
         scl <= 1'b0;
      end
      rx = s[8:1];
      ack = s[0];
   endtask : byte_x
endmodule : dpw_mst

// File: test/dpw_props.sv
// concurrent checks on the wiper command handler ports
`timescale 1ns/1ps
module dpw_props #(
   parameter int PROG_CYCLES = 50
) (
   input wire logic       CLK_SYS,
   input wire logic       SYS_RST,
   input wire logic       SDA_OE_N,
   input wire logic       WRITE_PERMIT_LATCH,
   input wire logic [7:0] WIPER_POT64,
   input wire logic [7:0] WIPER_POT100,
   input wire logic [7:0] WIPER_POT256,
   input wire logic [7:0] STORED_POT64,
   input wire logic [7:0] STORED_POT256,
   input wire logic       PROG_BUSY
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);
   int busy_cnt_q;
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || !PROG_BUSY)
         busy_cnt_q <= 0;
      else
         busy_cnt_q <= busy_cnt_q + 1;
   end
   sequence s_locked;
      !WRITE_PERMIT_LATCH [*6];
   endsequence
   a_busy_no_ack: assert property (PROG_BUSY |-> SDA_OE_N)
      else $error("ack while programming");
   a_busy_held: assert property (PROG_BUSY && busy_cnt_q < PROG_CYCLES - 2 |=> PROG_BUSY)
      else $error("programming ended early");
   a_busy_bounded: assert property (busy_cnt_q <= PROG_CYCLES + 1)
      else $error("programming too long");
   a_nv_prog: assert property ($changed(STORED_POT256) |-> ##[0:60] PROG_BUSY)
      else $error("stored write without programming");
   a_nv_pair64: assert property ($changed(STORED_POT64) |-> WIPER_POT64 == STORED_POT64)
      else $error("wiper and stored copy differ");
   a_nv_pair256: assert property ($changed(STORED_POT256) |-> WIPER_POT256 == STORED_POT256)
      else $error("wiper and stored copy differ");
   a_clamp_64: assert property (WIPER_POT64 <= dpw_pkg::MAX_POT64)
      else $error("wiper above top tap");
   a_clamp_100: assert property (WIPER_POT100 <= dpw_pkg::MAX_POT100)
      else $error("wiper above top tap");
   a_permit_guard: assert property (s_locked |=> $stable({WIPER_POT64, WIPER_POT256}))
      else $error("write while locked");
   a_reset_state: assert property ($fell(SYS_RST) |-> STORED_POT64 == 8'h00 && !PROG_BUSY)
      else $error("bad state after reset");
endmodule : dpw_props
bind dpw_top dpw_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SDA_OE_N(SDA_OE_N),
   .WRITE_PERMIT_LATCH(WRITE_PERMIT_LATCH), .PROG_BUSY(PROG_BUSY),
   .WIPER_POT64(WIPER_POT64), .WIPER_POT100(WIPER_POT100), .WIPER_POT256(WIPER_POT256),
   .STORED_POT64(STORED_POT64), .STORED_POT256(STORED_POT256)
);

// File: test/testbench.sv
// self-checking bench for the wiper command handler
`timescale 1ns/1ps
module testbench;
   localparam int PROG_N = 200;
   localparam logic [7:0] W_INS [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h02};
   localparam logic [7:0] W_DAT [6] = '{8'h0F, 8'h80, 8'hC8, 8'h63, 8'hFF, 8'h00};
   localparam logic [7:0] W_EXP [6] = '{8'h0F, 8'h3F, 8'h7F, 8'h63, 8'hFF, 8'h00};
   localparam logic [7:0] R_EXP [3] = '{8'h3F, 8'h63, 8'hA5};
   localparam logic [7:0] R_MSK [3] = '{8'h3F, 8'h7F, 8'hFF};
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic       permit  = 1'b1;
   wire logic  scl;
   wire logic  sda;
   logic       sda_out;
   logic       sda_oe_n;
   logic       busy;
   logic [7:0] wp [3];
   logic [7:0] st [3];
   int         error_cnt  = 0;
   int         n_compared = 0;
   initial forever #4 clk_sys = ~clk_sys;
   dpw_top #(.PROG_CYCLES(PROG_N)) i_dut (
      .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .WRITE_PERMIT_LATCH(permit),
      .WIPER_POT64(wp[0]), .WIPER_POT100(wp[1]), .WIPER_POT256(wp[2]),
      .STORED_POT64(st[0]), .STORED_POT100(st[1]), .STORED_POT256(st[2]),
      .PROG_BUSY(busy)
   );
   dpw_mst i_mst (.clk(clk_sys), .dev_sda(sda_out), .dev_oe_n(sda_oe_n), .scl(scl), .sda(sda));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   // start and address byte; a low ack slot means acknowledged
   task automatic addr(input logic [7:0] a, input logic exp);
      logic [7:0] rx;
      logic       ack;
      i_mst.cond(1'b1, 1'b0);
      i_mst.byte_x(a, 1'b1, rx, ack);
      chk("addr ack", {7'h00, exp}, {7'h00, ack});
   endtask : addr
   task automatic pot_wr(input logic [7:0] ins, input logic [7:0] dat, input logic exp);
      logic [7:0] rx;
      logic       ack;
      addr(8'hAE, 1'b0);
      i_mst.byte_x(ins, 1'b1, rx, ack);
      chk("instr ack", {7'h00, exp}, {7'h00, ack});
      i_mst.byte_x(dat, 1'b1, rx, ack);
      i_mst.cond(1'b0, 1'b1);
   endtask : pot_wr
   task automatic pot_rd(input logic [1:0] sel, output logic [7:0] rd);
      logic ack;
      addr(8'hAE, 1'b0);
      i_mst.byte_x({6'h20, sel}, 1'b1, rd, ack);
      chk("instr ack", 8'h00, {7'h00, ack});
      addr(8'hAF, 1'b0);
      i_mst.byte_x(8'hFF, 1'b1, rd, ack);
      i_mst.cond(1'b0, 1'b1);
   endtask : pot_rd
   initial begin
      logic [7:0] rd;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < 3; i++) begin
         chk("stored", dpw_pkg::NV_DEFAULT, st[i]);
         chk("wiper", dpw_pkg::NV_DEFAULT, wp[i]);
      end
      $display("test power_up done");
      for (int i = 0; i < 6; i++) begin
         pot_wr(W_INS[i], W_DAT[i], 1'b0);
         chk("wiper", W_EXP[i], wp[W_INS[i][1:0]]);
         chk("stored", dpw_pkg::NV_DEFAULT, st[W_INS[i][1:0]]);
      end
      $display("test volatile_write done");
      pot_wr(8'h82, 8'hA5, 1'b0);
      i_mst.tick(4);
      chk("stored", 8'hA5, st[2]);
      chk("wiper", 8'hA5, wp[2]);
      chk("busy", 8'h01, {7'h00, busy});
      addr(8'hAE, 1'b1);
      i_mst.cond(1'b0, 1'b1);
      for (int n = 0; n < 2 * PROG_N && busy !== 1'b0; n++)
         @(posedge clk_sys);
      chk("busy", 8'h00, {7'h00, busy});
      if (busy !== 1'b0)
         close_out();
      addr(8'hAE, 1'b0);
      i_mst.cond(1'b0, 1'b1);
      $display("test nonvolatile_write done");
      for (int i = 0; i < 3; i++) begin
         pot_rd(2'(i), rd);
         chk("read", R_EXP[i] & R_MSK[i], rd & R_MSK[i]);
      end
      $display("test read done");
      pot_wr(8'h03, 8'h10, 1'b1);
      addr(8'hA0, 1'b1);
      i_mst.cond(1'b0, 1'b1);
      permit <= 1'b0;
      i_mst.tick(8);
      pot_wr(8'h02, 8'h11, 1'b0);
      chk("wiper", 8'hA5, wp[2]);
      permit <= 1'b1;
      $display("test refusals done");
      close_out();
   end
endmodule : testbench
